// file: core/apmg_pkg.sv
// package: register map, field layout, reset values and timing for the pm control block
package apmg_pkg;

	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int EVT_W = 8;
	localparam int NUM_STATES = 6;

	// ----------------------------------------------------------------
	// register indices and byte addresses (byte address = base + 4 * index)
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_LOW_IDX = 8'h00;
	localparam logic [7:0] CTRL_HIGH_IDX = 8'h01;
	localparam logic [7:0] EVT_STS_IDX = 8'h00;
	localparam logic [7:0] CTRL_BASE = 8'h00;
	localparam logic [7:0] EVT_BASE = 8'h20;
	localparam logic [7:0] ADDR_CTRL_LOW = 8'(CTRL_BASE + 8'h04 * CTRL_LOW_IDX);
	localparam logic [7:0] ADDR_CTRL_HIGH = 8'(CTRL_BASE + 8'h04 * CTRL_HIGH_IDX);
	localparam logic [7:0] ADDR_EVT_STS = 8'(EVT_BASE + 8'h04 * EVT_STS_IDX);
	localparam logic [7:0] ADDR_EVT_MASK = 8'h24;
	localparam logic [7:0] ADDR_EVT_POL = 8'h28;
	localparam logic [7:0] ADDR_EVT_DBN = 8'h2c;
	localparam logic [7:0] ADDR_SYS_STATE = 8'h30;
	localparam logic [7:0] ADDR_ENC_BASE = 8'h40;

	// ----------------------------------------------------------------
	// fields of sleep_control_high
	// ----------------------------------------------------------------
	localparam int SLEEP_ENABLE_BIT = 5;
	localparam int SLP_TYPE_LSB = 2;
	localparam int SLP_TYPE_W = 3;

	typedef struct packed {
		logic [1:0] rsvd_hi;
		logic sleep_enable;
		logic [2:0] sleep_type;
		logic ignored;
		logic rsvd_lo;
	} apmg_ctl_high_t;

	// system state seen by the rest of the chip
	typedef struct packed {
		logic [NUM_STATES-1:0] sel;
		logic [SLP_TYPE_W-1:0] code;
	} apmg_state_t;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] SLP_TYPE_RST = 3'h0;
	localparam logic [7:0] EVT_RST = 8'h00;
	localparam logic [5:0][2:0] ENC_RST = {3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int SYS_CLK_MHZ = 50;
	localparam int DEBOUNCE_US = 1000;
	localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * SYS_CLK_MHZ;

endpackage

// file: core/apmg_top.sv
// pm sleep control bytes and gpio event status byte behind an avalon-mm slave
// Notes on behaviour
// - low control byte is read-only and reads all zero.
// - unbuilt high control bits 7-6 and 0 read zero.
// - writing one to sleep enable loads sleep type as system state code.
// - same write setting enable and new type adopts the new type.
// - sleep enable acts on write and always reads zero.
// - three-bit read/write sleep type at high bits 4-2, resets to 000.
// - codes select working S0, sleeping S1-S4 and soft-off S5.
// - six per-state encoding registers give codes; one state 000, others nonzero.
// - high bit 1 discards writes; its read value is free.
// - event status bit sets while its event is high and sticks.
// - writing one clears a status bit, zero keeps it; reset clears all.
// - status bits 7-0 follow gpio event port 1 pins 7-0.
// - per-pin polarity and optional debounce condition each pin first.
// - control bytes at 00h and 01h, event status at 00h of its group.
`timescale 1ns/1ns
`default_nettype none

module apmg_top
	import apmg_pkg::*;
#(
	parameter int DEBOUNCE_CNT = apmg_pkg::DEBOUNCE_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [apmg_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [apmg_pkg::DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [apmg_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [apmg_pkg::EVT_W-1:0] gpio_event_port,
	output logic irq,
	output logic sleep_entry,
	output apmg_pkg::apmg_state_t sys_state
);
	import apmg_pkg::*;

	localparam int DB_W = $clog2(DEBOUNCE_CNT + 1);

	// ----------------------------------------------------------------
	// bus handshake
	// ----------------------------------------------------------------
	// one wait cycle on every access keeps read data coming from a flop
	// trade-off: half the peak bus rate for a registered answer
	typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} apmg_bus_t;

	apmg_bus_t bus_r;
	logic wait_r;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rd_nxt;
	logic req;
	logic wr_ack;

	assign req = avs_read | avs_write;
	// writes land only at the edge where the master sees waitrequest low
	assign wr_ack = (bus_r == BUS_ACK) && avs_write && avs_byteenable[0];

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			bus_r <= BUS_IDLE;
			wait_r <= 1'b1;
		end else begin
			case (bus_r)
				BUS_IDLE: begin
					if (req) begin
						bus_r <= BUS_ACK;
						wait_r <= 1'b0;
					end
				end
				BUS_ACK: begin
					bus_r <= BUS_IDLE;
					wait_r <= 1'b1;
				end
				default: begin
					bus_r <= BUS_IDLE;
					wait_r <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// sleep control
	// ----------------------------------------------------------------
	logic [2:0] sleep_type_r;
	logic [2:0] state_code_r;
	logic sleep_pulse_r;
	apmg_ctl_high_t wr_high;
	logic wr_ctl_high;

	assign wr_high = apmg_ctl_high_t'(avs_writedata[7:0]);
	// low byte has nothing writable; bit 1 and reserved bits of high are dropped
	assign wr_ctl_high = wr_ack && (avs_address == ADDR_CTRL_HIGH);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sleep_type_r <= SLP_TYPE_RST;
		end else if (wr_ctl_high) begin
			sleep_type_r <= wr_high.sleep_type;
		end
	end

	// the written type is used, so a combined enable+type write adopts the new code
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_code_r <= SLP_TYPE_RST;
			sleep_pulse_r <= 1'b0;
		end else begin
			sleep_pulse_r <= wr_ctl_high && wr_high.sleep_enable;
			if (wr_ctl_high && wr_high.sleep_enable) begin
				state_code_r <= wr_high.sleep_type;
			end
		end
	end

	// ----------------------------------------------------------------
	// per-state encoding table
	// ----------------------------------------------------------------
	logic [NUM_STATES-1:0][2:0] enc_r;
	logic [NUM_STATES-1:0] sel_r;
	logic [NUM_STATES-1:0] sel_nxt;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			enc_r <= ENC_RST;
		end else begin
			for (int i = 0; i < NUM_STATES; i++) begin
				if (wr_ack && avs_address == 8'(ADDR_ENC_BASE + 4 * i)) begin
					enc_r[i] <= avs_writedata[2:0];
				end
			end
		end
	end

	// first matching entry wins if software programs two states alike
	always_comb begin
		sel_nxt = '0;
		for (int i = NUM_STATES - 1; i >= 0; i--) begin
			if (enc_r[i] == state_code_r) begin
				sel_nxt = '0;
				sel_nxt[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sel_r <= '0;
		end else begin
			sel_r <= sel_nxt;
		end
	end

	// ----------------------------------------------------------------
	// gpio event conditioning
	// ----------------------------------------------------------------
	logic [EVT_W-1:0] pol_r;
	logic [EVT_W-1:0] dbn_r;
	logic [EVT_W-1:0] cond_r;
	logic [EVT_W-1:0] raw;

	assign raw = gpio_event_port ^ pol_r;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pol_r <= EVT_RST;
			dbn_r <= EVT_RST;
		end else begin
			if (wr_ack && avs_address == ADDR_EVT_POL) begin
				pol_r <= avs_writedata[EVT_W-1:0];
			end
			if (wr_ack && avs_address == ADDR_EVT_DBN) begin
				dbn_r <= avs_writedata[EVT_W-1:0];
			end
		end
	end

	// debounce: output follows input only after it held steady for the full count
	// limitation: a pin that toggles faster than the count never reaches status
	genvar g;
	generate
		for (g = 0; g < EVT_W; g++) begin : g_pin
			logic [DB_W-1:0] cnt_r;
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					cnt_r <= '0;
					cond_r[g] <= 1'b0;
				end else if (!dbn_r[g] || raw[g] == cond_r[g]) begin
					cnt_r <= '0;
					cond_r[g] <= raw[g];
				end else if (cnt_r == DB_W'(DEBOUNCE_CNT - 1)) begin
					cnt_r <= '0;
					cond_r[g] <= raw[g];
				end else begin
					cnt_r <= DB_W'(cnt_r + 1'b1);
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// event status, mask and interrupt
	// ----------------------------------------------------------------
	logic [EVT_W-1:0] sts_r;
	logic [EVT_W-1:0] mask_r;
	logic [EVT_W-1:0] clr;
	logic irq_r;

	assign clr = (wr_ack && avs_address == ADDR_EVT_STS) ? avs_writedata[EVT_W-1:0] : '0;

	// set beats clear so an event during the clearing write is kept
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sts_r <= EVT_RST;
		end else begin
			sts_r <= (sts_r & ~clr) | cond_r;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mask_r <= EVT_RST;
		end else if (wr_ack && avs_address == ADDR_EVT_MASK) begin
			mask_r <= avs_writedata[EVT_W-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(sts_r & mask_r);
		end
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_nxt = '0;
		case (avs_address)
			ADDR_CTRL_LOW: rd_nxt = '0;
			// enable, bit 1 and reserved bits all read zero
			ADDR_CTRL_HIGH: rd_nxt[SLP_TYPE_LSB +: SLP_TYPE_W] = sleep_type_r;
			ADDR_EVT_STS: rd_nxt[EVT_W-1:0] = sts_r;
			ADDR_EVT_MASK: rd_nxt[EVT_W-1:0] = mask_r;
			ADDR_EVT_POL: rd_nxt[EVT_W-1:0] = pol_r;
			ADDR_EVT_DBN: rd_nxt[EVT_W-1:0] = dbn_r;
			ADDR_SYS_STATE: rd_nxt[13:0] = {sel_r, 5'h00, state_code_r};
			default: begin
				for (int i = 0; i < NUM_STATES; i++) begin
					if (avs_address == 8'(ADDR_ENC_BASE + 4 * i)) begin
						rd_nxt[2:0] = enc_r[i];
					end
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rdata_r <= '0;
		end else if (bus_r == BUS_IDLE && avs_read) begin
			rdata_r <= rd_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;
	assign irq = irq_r;
	assign sleep_entry = sleep_pulse_r;
	assign sys_state = apmg_state_t'({sel_r, state_code_r});

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	logic rd_ack;
	assign rd_ack = (bus_r == BUS_ACK) && avs_read;

	a_low_reads_zero: assert property (
		rd_ack && avs_address == ADDR_CTRL_LOW |-> avs_readdata == '0)
		else $error("low control byte read nonzero");

	a_high_unbuilt_zero: assert property (
		rd_ack && avs_address == ADDR_CTRL_HIGH |->
			avs_readdata[7:5] == 3'h0 && avs_readdata[1:0] == 2'h0
			&& avs_readdata[4:2] == sleep_type_r)
		else $error("high control byte read wrong");

	a_sleep_latch: assert property (
		wr_ctl_high && wr_high.sleep_enable |=>
			state_code_r == $past(avs_writedata[4:2]) && sleep_entry
			##1 !sleep_entry)
		else $error("sleep enable did not load state code");

	a_state_hold: assert property (
		!(wr_ctl_high && wr_high.sleep_enable) |=> $stable(state_code_r) && !sleep_entry)
		else $error("state code changed without sleep enable");

	a_type_write: assert property (
		wr_ctl_high |=> sleep_type_r == $past(avs_writedata[4:2]))
		else $error("sleep type not written");

	a_sel_match: assert property (
		$stable(state_code_r) && $stable(enc_r) |->
			$onehot0(sel_r) && (sel_r == '0 || enc_r[$clog2(sel_r)] == state_code_r))
		else $error("state select does not match code");

	a_event_sets: assert property (
		|cond_r |=> (sts_r & $past(cond_r)) == $past(cond_r))
		else $error("active event did not set status");

	a_w1c_clear: assert property (
		|clr |=> (sts_r & $past(clr) & ~$past(cond_r)) == '0
			&& (sts_r & ~$past(clr)) == (($past(sts_r) | $past(cond_r)) & ~$past(clr)))
		else $error("write one to clear misbehaved");

	a_wait_bound: assert property (
		req && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
		else $error("waitrequest never dropped");

	a_irq_level: assert property (
		irq == |($past(sts_r) & $past(mask_r)))
		else $error("interrupt does not follow masked status");

	a_sel_none: assert property (
		rst_n && $past(rst_n) && $stable(state_code_r) && $stable(enc_r)
			&& sel_r == '0 |->
			enc_r[0] != state_code_r && enc_r[1] != state_code_r
			&& enc_r[2] != state_code_r && enc_r[3] != state_code_r
			&& enc_r[4] != state_code_r && enc_r[5] != state_code_r)
		else $error("no state selected although an encoding matches");

	a_wait_pulse: assert property (
		!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");

	a_wait_idle: assert property (
		!req && avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest dropped with no request");

	a_rdata_hold: assert property (
		!avs_read |=> $stable(avs_readdata))
		else $error("read data changed without a read");

	a_low_write_inert: assert property (
		wr_ack && avs_address == ADDR_CTRL_LOW |=>
			$stable(sleep_type_r) && $stable(state_code_r))
		else $error("write to low control byte changed state");

	a_enc_write: assert property (
		wr_ack && avs_address == 8'(ADDR_ENC_BASE + 8'h08) |=>
			enc_r[2] == $past(avs_writedata[2:0]))
		else $error("encoding entry not written");

	a_raw_follow: assert property (
		rst_n && dbn_r == '0 |=> cond_r == $past(raw))
		else $error("undebounced pins not passed straight through");

	a_sts_no_spurious: assert property (
		(sts_r & ~$past(sts_r) & ~$past(cond_r)) == '0)
		else $error("status bit set without an active event");

	c_sleep_entry: cover property (wr_ctl_high && wr_high.sleep_enable ##1 sleep_entry);
	c_event_clear: cover property (|sts_r ##1 |clr ##1 sts_r == '0);
	c_irq_raise: cover property (!irq ##1 irq);
	c_set_vs_clear: cover property (|(clr & cond_r));
	c_debounce_pass: cover property (dbn_r[0] ##1 $rose(cond_r[0]));

endmodule

`default_nettype wire

// file: tb/tb_top.sv
// testbench: register, sleep-state and gpio event checks for the pm control block
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	import apmg_pkg::*;
	// short debounce so the filtered path is reachable in a few cycles
	localparam int DBN = 4;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [DATA_W-1:0] avs_writedata = '0;
	logic [3:0] avs_byteenable = 4'h0;
	logic [DATA_W-1:0] avs_readdata;
	logic avs_waitrequest;
	logic [EVT_W-1:0] gpio_event_port = '0;
	logic irq;
	logic sleep_entry;
	apmg_state_t sys_state;
	int num_errors = 0;
	int checks = 0;
	logic [31:0] rd;

	always #10 sys_clk = ~sys_clk;

	apmg_top #(.DEBOUNCE_CNT(DBN)) u_apmg_top (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.gpio_event_port(gpio_event_port),
		.irq(irq),
		.sleep_entry(sleep_entry),
		.sys_state(sys_state)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task print_verdict;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s: got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one avalon transfer; request held until waitrequest is sampled low
	task bus(input logic is_wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		int n;
		@(posedge sys_clk);
		avs_address <= a;
		avs_write <= is_wr;
		avs_read <= ~is_wr;
		avs_writedata <= d;
		avs_byteenable <= be;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (avs_waitrequest !== 1'b0) begin
			num_errors++;
			$display("[FAIL] %0t bus timeout", $time);
			print_verdict();
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'h1);
	endtask

	task rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0, 4'hf);
		chk(rd, exp, what);
	endtask

	task pins(input logic [7:0] v, input int hold);
		@(posedge sys_clk);
		gpio_event_port <= v;
		repeat (hold) @(posedge sys_clk);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_reset;
		rdchk(ADDR_CTRL_LOW, 32'h0, "ctrl low reset");
		rdchk(ADDR_CTRL_HIGH, 32'h0, "ctrl high reset");
		rdchk(ADDR_EVT_STS, 32'h0, "event status reset");
		chk(32'(sys_state.code), 32'h0, "state code reset");
		chk(32'(sys_state.sel), 32'h1, "S0 selected");
		chk(32'(irq), 32'h0, "irq reset");
	endtask

	task t_ctrl;
		wr(ADDR_CTRL_LOW, 32'hffff_ffff);
		rdchk(ADDR_CTRL_LOW, 32'h0, "ctrl low stays zero");
		wr(ADDR_CTRL_HIGH, 32'h0000_00df);
		rdchk(ADDR_CTRL_HIGH, 32'h1c, "only type bits read");
		chk(32'(sys_state.code), 32'h0, "no enable no state change");
		bus(1'b1, ADDR_CTRL_HIGH, 32'h0000_0008, 4'h0);
		rdchk(ADDR_CTRL_HIGH, 32'h1c, "byte disabled write ignored");
		rdchk(8'hfc, 32'h0, "unmapped reads zero");
	endtask

	task t_sleep;
		for (int t = 0; t < NUM_STATES; t++) begin
			wr(ADDR_CTRL_HIGH, 32'h20 | 32'(t << 2));
			@(negedge sys_clk);
			chk(32'(sleep_entry), 32'h1, "sleep entry pulse");
			chk(32'(sys_state.code), 32'(t), "new type adopted");
			@(negedge sys_clk);
			chk(32'(sleep_entry), 32'h0, "pulse one cycle");
			chk(32'(sys_state.sel), 32'(1 << t), "state select");
			rdchk(ADDR_CTRL_HIGH, 32'(t << 2), "enable reads zero");
			rdchk(ADDR_SYS_STATE, 32'(1 << (t + 8)) | 32'(t), "state register");
		end
		wr(ADDR_ENC_BASE + 8'h08, 32'h6);
		wr(ADDR_CTRL_HIGH, 32'h38);
		repeat (2) @(negedge sys_clk);
		chk(32'(sys_state.sel), 32'h4, "reprogrammed S2 code");
		wr(ADDR_ENC_BASE + 8'h08, 32'h2);
		wr(ADDR_CTRL_HIGH, 32'h20);
	endtask

	task t_event;
		for (int i = 0; i < EVT_W; i++) begin
			pins(8'(1 << i), 3);
			pins(8'h00, 0);
			rdchk(ADDR_EVT_STS, 32'(1 << i), "pin sets its bit");
			wr(ADDR_EVT_STS, 32'h0);
			rdchk(ADDR_EVT_STS, 32'(1 << i), "write zero keeps");
			wr(ADDR_EVT_STS, 32'(1 << i));
			rdchk(ADDR_EVT_STS, 32'h0, "write one clears");
		end
		pins(8'h01, 3);
		wr(ADDR_EVT_STS, 32'h1);
		rdchk(ADDR_EVT_STS, 32'h1, "clear while active keeps");
		pins(8'h00, 3);
		wr(ADDR_EVT_STS, 32'h1);
		rdchk(ADDR_EVT_STS, 32'h0, "clear after release");
	endtask

	task t_irq;
		wr(ADDR_EVT_MASK, 32'h04);
		rdchk(ADDR_EVT_MASK, 32'h04, "mask reads back");
		pins(8'h08, 3);
		pins(8'h00, 4);
		chk(32'(irq), 32'h0, "masked event no irq");
		pins(8'h04, 3);
		pins(8'h00, 4);
		chk(32'(irq), 32'h1, "unmasked event irq");
		wr(ADDR_EVT_MASK, 32'h00);
		repeat (2) @(negedge sys_clk);
		chk(32'(irq), 32'h0, "mask drops irq");
		wr(ADDR_EVT_MASK, 32'h04);
		wr(ADDR_EVT_STS, 32'h0c);
		repeat (2) @(negedge sys_clk);
		chk(32'(irq), 32'h0, "clear drops irq");
	endtask

	task t_cond;
		wr(ADDR_EVT_POL, 32'h02);
		rdchk(ADDR_EVT_POL, 32'h02, "polarity reads back");
		repeat (4) @(posedge sys_clk);
		rdchk(ADDR_EVT_STS, 32'h02, "low active pin");
		pins(8'h02, 2);
		wr(ADDR_EVT_STS, 32'h02);
		rdchk(ADDR_EVT_STS, 32'h0, "high pin inactive");
		wr(ADDR_EVT_POL, 32'h0);
		pins(8'h00, 4);
		wr(ADDR_EVT_STS, 32'hff);
		wr(ADDR_EVT_DBN, 32'h01);
		pins(8'h01, 2);
		pins(8'h00, 10);
		rdchk(ADDR_EVT_STS, 32'h0, "short pulse filtered");
		pins(8'h01, 12);
		pins(8'h00, 12);
		rdchk(ADDR_EVT_STS, 32'h1, "long level passes");
		wr(ADDR_EVT_DBN, 32'h0);
	endtask

	// second reset in mid-run with state, status and mask all nonzero
	task t_rerun;
		wr(ADDR_CTRL_HIGH, 32'h2c);
		wr(ADDR_EVT_MASK, 32'h01);
		repeat (2) @(negedge sys_clk);
		chk(32'(sys_state.code), 32'h3, "code before reset");
		chk(32'(irq), 32'h1, "irq before reset");
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(negedge sys_clk);
		chk(32'(sys_state), 32'h0, "state cleared by reset");
		chk(32'(irq), 32'h0, "irq cleared by reset");
		chk(32'(avs_waitrequest), 32'h1, "waitrequest idle after reset");
		rdchk(ADDR_CTRL_HIGH, 32'h0, "type reset to 000");
		rdchk(ADDR_EVT_STS, 32'h0, "status reset clears");
		rdchk(ADDR_EVT_MASK, 32'h0, "mask reset clears");
		rdchk(ADDR_SYS_STATE, 32'h100, "S0 after reset");
	endtask

	initial begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset();
		t_ctrl();
		t_sleep();
		t_event();
		t_irq();
		t_cond();
		t_rerun();
		print_verdict();
	end
endmodule

`default_nettype wire
